// ---- ioc_indirect_ctrl.sv ----
// Indirect peek/poke and fault-log read path plus on/off/margin decoding.
// Assumes a bus decoder on the same clock hands over one command per accepted cycle,
// and a serial fault-log feed whose clock is sampled as an ordinary pin.
`timescale 1ns/1ps
module ioc_indirect_ctrl #(
	parameter int INIT_CYCLES = ioc_pkg::INIT_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_chan,
	input wire logic [15:0] cmd_wdata,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [15:0] rsp_data,
	output logic peek_req,
	output logic poke_valid,
	output logic [4:0] tgt_chan,
	output logic [8:0] tgt_code,
	output logic [15:0] poke_data,
	input wire logic [15:0] peek_rdata,
	input wire logic peek_is_byte,
	input wire logic log_sck,
	input wire logic log_sdi,
	input wire logic log_frame_n,
	input wire logic bus_honour,
	input wire logic input_supply_sense,
	output logic seq_permit,
	output logic [ioc_pkg::N_CHAN-1:0] chan_on,
	output logic [ioc_pkg::N_CHAN-1:0] chan_seq_off,
	output logic [ioc_pkg::N_CHAN-1:0] chan_margin_low,
	output logic [ioc_pkg::N_CHAN-1:0] chan_margin_high,
	output logic [ioc_pkg::N_CHAN-1:0] chan_ignore_faults
);
	import ioc_pkg::*;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic cmd_ready_q;
	logic acc;
	logic hs;
	logic wr_plus;
	logic poke_ctrl;
	logic rd_port;
	logic wr_port;
	logic log_wr_start;
	logic abort_all;
	logic [N_HOST-1:0][8:0] ptr_q;
	logic [N_HOST-1:0][4:0] chan_q;
	logic [N_HOST-1:0][7:0] idx_q;
	logic [N_HOST-1:0] active_q;
	logic [N_HOST-1:0] abort_q;
	logic [N_HOST-1:0] poke_en_q;
	logic [N_HOST-1:0] poke_fail_q;
	logic [7:0] log_mem [0:255];

	assign acc = cmd_valid & cmd_ready_q;
	assign hs = (cmd_code == CODE_DATA_PLUS_B);
	assign wr_plus = acc & cmd_write & (cmd_code == CODE_CMD_PLUS);
	assign poke_ctrl = (cmd_wdata[PTR_HI:0] == PTR_POKE_CTRL);
	assign rd_port = acc & ~cmd_write & ((cmd_code == CODE_DATA_PLUS_A) | hs);
	assign wr_port = acc & cmd_write & ((cmd_code == CODE_DATA_PLUS_A) | hs);
	// A log store, a standard log block read or a buffer refill ends any block peek.
	assign abort_all = log_wr_start | (acc & cmd_write & (cmd_code == CODE_LOG_STORE)) |
		(acc & ~cmd_write & (cmd_code == CODE_FAULT_LOG));

	// ----------------------------------------------------------------
	// Per-host pointer, stream position and status
	// ----------------------------------------------------------------
	for (genvar h = 0; h < N_HOST; h++) begin : g_host
		logic mine_plus;
		logic mine_port;
		assign mine_plus = wr_plus & (cmd_wdata[HOST_SEL_BIT] == 1'(h));
		assign mine_port = (hs == 1'(h));

		always_ff @(posedge clock) begin
			if (!rstn) begin
				ptr_q[h] <= 9'h000;
				chan_q[h] <= 5'h00;
			end else if (mine_plus && !poke_ctrl) begin
				ptr_q[h] <= cmd_wdata[PTR_HI:0];
				chan_q[h] <= cmd_wdata[CHAN_HI:CHAN_LO];
			end
		end

		always_ff @(posedge clock) begin
			if (!rstn) begin
				idx_q[h] <= 8'h00;
				active_q[h] <= 1'b0;
				abort_q[h] <= 1'b0;
			end else begin
				if (mine_plus && !poke_ctrl) begin
					idx_q[h] <= 8'h00;
					active_q[h] <= (cmd_wdata[PTR_HI:0] == PTR_FAULT_LOG);
					if (cmd_wdata[PTR_HI:0] == PTR_FAULT_LOG) begin
						abort_q[h] <= 1'b0;
					end
				end else if (rd_port && mine_port && ptr_q[h] == PTR_FAULT_LOG &&
					idx_q[h] <= LOG_LAST_WORD) begin
					idx_q[h] <= idx_q[h] + 8'h01;
				end
				// The abort is checked last so that it wins over a same-cycle restart of a stream that is already active.
				if (abort_all && active_q[h]) begin
					abort_q[h] <= 1'b1;
					active_q[h] <= 1'b0;
				end
			end
		end

		always_ff @(posedge clock) begin
			if (!rstn) begin
				poke_en_q[h] <= 1'b0;
				poke_fail_q[h] <= 1'b0;
			end else begin
				if (mine_plus && poke_ctrl && cmd_wdata[CHAN_HI:CHAN_LO] == POKE_EN_CHAN) begin
					poke_en_q[h] <= 1'b1;
				end else if (mine_plus && poke_ctrl && cmd_wdata[CHAN_HI:CHAN_LO] == POKE_DIS_CHAN) begin
					poke_en_q[h] <= 1'b0;
				end
				if (wr_port && mine_port) begin
					poke_fail_q[h] <= ~poke_en_q[h];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Read answer selection
	// ----------------------------------------------------------------
	logic [7:0] widx;
	logic [7:0] a_lo;
	logic [7:0] a_hi;
	logic [15:0] log_word;
	logic [7:0] op_q [N_CHAN];
	logic peek_req_q;
	logic peek_start;
	logic push;
	logic [15:0] push_data;

	assign widx = idx_q[hs];
	assign a_lo = {widx[6:0], 1'b0} - 8'h02;
	assign a_hi = {widx[6:0], 1'b1} - 8'h02;

	always_comb begin
		if (!active_q[hs]) begin
			log_word = 16'h0000;
		end else if (widx == 8'h00) begin
			log_word = LOG_LENGTH_WORD;
		end else if (widx <= LOG_LAST_WORD) begin
			// Earlier byte in the low half; the byte after the last one reads zero.
			log_word = {(a_hi > LOG_LAST_BYTE) ? 8'h00 : log_mem[a_hi], log_mem[a_lo]};
		end else begin
			log_word = 16'h0000;
		end
	end

	always_comb begin
		push = 1'b0;
		push_data = 16'h0000;
		peek_start = 1'b0;
		if (peek_req_q) begin
			push = 1'b1;
			push_data = {peek_is_byte ? 8'h00 : peek_rdata[15:8], peek_rdata[7:0]};
		end else if (rd_port && ptr_q[hs] == PTR_FAULT_LOG) begin
			push = 1'b1;
			push_data = log_word;
		end else if (rd_port && ptr_q[hs] == PTR_STATUS_A) begin
			push = 1'b1;
			push_data = {14'h0000, abort_q[0], poke_fail_q[0]};
		end else if (rd_port && ptr_q[hs] == PTR_STATUS_B) begin
			push = 1'b1;
			push_data = {14'h0000, abort_q[1], poke_fail_q[1]};
		end else if (rd_port) begin
			peek_start = 1'b1;
		end else if (acc && !cmd_write && cmd_code == CODE_OPERATION) begin
			push = 1'b1;
			push_data = {8'h00, op_q[cmd_chan[2:0]]};
		end
	end

	// ----------------------------------------------------------------
	// Target port for peeks and pokes
	// ----------------------------------------------------------------
	logic poke_valid_q;
	logic [4:0] tgt_chan_q;
	logic [8:0] tgt_code_q;
	logic [15:0] poke_data_q;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			peek_req_q <= 1'b0;
			poke_valid_q <= 1'b0;
			tgt_chan_q <= 5'h00;
			tgt_code_q <= 9'h000;
			poke_data_q <= 16'h0000;
		end else begin
			peek_req_q <= peek_start;
			poke_valid_q <= wr_port & poke_en_q[hs];
			if (peek_start || wr_port) begin
				tgt_chan_q <= chan_q[hs];
				tgt_code_q <= ptr_q[hs];
				poke_data_q <= cmd_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Two-entry answer buffer
	// ----------------------------------------------------------------
	// Commands are held off while an answer could find no room, so a stalled
	// receiver never loses a word.
	logic ent0_v_q;
	logic ent1_v_q;
	logic [15:0] ent0_q;
	logic [15:0] ent1_q;
	logic ent0_v_d;
	logic ent1_v_d;
	logic [15:0] ent0_d;
	logic [15:0] ent1_d;
	logic pop;

	assign pop = ent0_v_q & rsp_ready;

	always_comb begin
		ent0_v_d = ent0_v_q;
		ent1_v_d = ent1_v_q;
		ent0_d = ent0_q;
		ent1_d = ent1_q;
		if (pop && ent1_v_q) begin
			ent0_d = ent1_q;
			ent1_v_d = push;
			ent1_d = push_data;
		end else if (pop) begin
			ent0_v_d = push;
			ent0_d = push_data;
		end else if (push && !ent0_v_q) begin
			ent0_v_d = 1'b1;
			ent0_d = push_data;
		end else if (push) begin
			ent1_v_d = 1'b1;
			ent1_d = push_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ent0_v_q <= 1'b0;
			ent1_v_q <= 1'b0;
			ent0_q <= 16'h0000;
			ent1_q <= 16'h0000;
			cmd_ready_q <= 1'b0;
		end else begin
			ent0_v_q <= ent0_v_d;
			ent1_v_q <= ent1_v_d;
			ent0_q <= ent0_d;
			ent1_q <= ent1_d;
			cmd_ready_q <= ~ent1_v_d & ~peek_start;
		end
	end

	// ----------------------------------------------------------------
	// Fault log feed, sampled serial link
	// ----------------------------------------------------------------
	logic [2:0] sck_q;
	logic [1:0] sdi_q;
	logic [2:0] frm_q;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [7:0] wptr_q;
	logic sck_rise;

	assign sck_rise = sck_q[1] & ~sck_q[2];
	assign log_wr_start = frm_q[2] & ~frm_q[1];

	always_ff @(posedge clock) begin
		if (!rstn) begin
			sck_q <= 3'h0;
			sdi_q <= 2'h0;
			frm_q <= 3'h7;
		end else begin
			sck_q <= {sck_q[1:0], log_sck};
			sdi_q <= {sdi_q[0], log_sdi};
			frm_q <= {frm_q[1:0], log_frame_n};
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			wptr_q <= 8'h00;
		end else if (log_wr_start) begin
			bit_q <= 3'h0;
			wptr_q <= 8'h00;
		end else if (sck_rise && !frm_q[1]) begin
			sh_q <= {sh_q[6:0], sdi_q[1]};
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7 && wptr_q <= LOG_LAST_BYTE) begin
				wptr_q <= wptr_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sck_rise && !frm_q[1] && bit_q == 3'h7 && wptr_q <= LOG_LAST_BYTE) begin
			log_mem[wptr_q] <= {sh_q[6:0], sdi_q[1]};
		end
	end

	// ----------------------------------------------------------------
	// Power-up gating
	// ----------------------------------------------------------------
	logic [31:0] init_cnt_q;
	logic init_done_q;
	logic [1:0] vin_q;
	logic seq_permit_q;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			init_cnt_q <= 32'h00000000;
			init_done_q <= 1'b0;
			vin_q <= 2'h0;
			seq_permit_q <= 1'b0;
		end else begin
			vin_q <= {vin_q[0], input_supply_sense};
			if (!init_done_q) begin
				init_cnt_q <= init_cnt_q + 32'h00000001;
			end
			init_done_q <= init_done_q | (init_cnt_q >= 32'(INIT_CYCLES - 1));
			seq_permit_q <= init_done_q & vin_q[1];
		end
	end

	// ----------------------------------------------------------------
	// On/off/margin per channel
	// ----------------------------------------------------------------
	logic op_wr;
	assign op_wr = acc & cmd_write & (cmd_code == CODE_OPERATION);

	for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
		logic hit;
		logic run_q;
		logic seq_off_q;
		logic [1:0] run_f;
		logic [1:0] mar_f;
		logic [1:0] flt_f;
		assign hit = op_wr & ((cmd_chan == GLOBAL_CHAN) | (cmd_chan == 8'(c)));
		assign run_f = op_q[c][RUN_HI:RUN_LO];
		assign mar_f = op_q[c][MARGIN_HI:MARGIN_LO];
		assign flt_f = op_q[c][FAULT_HI:FAULT_LO];

		always_ff @(posedge clock) begin
			if (!rstn) begin
				op_q[c] <= OP_RESET;
				run_q <= 1'b0;
				seq_off_q <= 1'b0;
			end else if (hit) begin
				op_q[c] <= {cmd_wdata[7:2], 2'h0};
				if (bus_honour && cmd_wdata[RUN_HI:RUN_LO] == RUN_ON) begin
					run_q <= 1'b1;
					seq_off_q <= 1'b0;
				end else if (bus_honour && cmd_wdata[RUN_HI:RUN_LO] == RUN_OFF) begin
					run_q <= 1'b0;
					seq_off_q <= 1'b0;
				end else if (bus_honour && cmd_wdata[RUN_HI:RUN_LO] == RUN_SEQ_OFF) begin
					run_q <= 1'b0;
					seq_off_q <= 1'b1;
				end
			end
		end

		always_ff @(posedge clock) begin
			if (!rstn) begin
				chan_on[c] <= 1'b0;
				chan_seq_off[c] <= 1'b0;
				chan_margin_low[c] <= 1'b0;
				chan_margin_high[c] <= 1'b0;
				chan_ignore_faults[c] <= 1'b0;
			end else begin
				chan_on[c] <= run_q & seq_permit_q;
				chan_seq_off[c] <= seq_off_q;
				chan_margin_low[c] <= (mar_f == MARGIN_LOW);
				chan_margin_high[c] <= (mar_f == MARGIN_HIGH);
				chan_ignore_faults[c] <= (mar_f == MARGIN_LOW || mar_f == MARGIN_HIGH) &&
					(flt_f == FAULT_IGNORE);
			end
		end
		// Run field kept for readback; the honoured copy lives in run_q.
		logic unused_run;
		assign unused_run = ^run_f;
	end

	assign cmd_ready = cmd_ready_q;
	assign rsp_valid = ent0_v_q;
	assign rsp_data = ent0_q;
	assign peek_req = peek_req_q;
	assign poke_valid = poke_valid_q;
	assign tgt_chan = tgt_chan_q;
	assign tgt_code = tgt_code_q;
	assign poke_data = poke_data_q;
	assign seq_permit = seq_permit_q;

endmodule : ioc_indirect_ctrl

// ---- ioc_pkg.sv ----
// Constants shared by the indirect access and output control block.
// Assumes a 40 MHz core clock and a command decoder on the same clock.
package ioc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	// Initialisation time; plain default, shortened through the top parameter.
	localparam int T_INIT_NS = 10000000;
	localparam int INIT_CYCLES_DEF = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int N_CHAN = 8;
	localparam int N_HOST = 2;

	// ----------------------------------------------------------------
	// Bus command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_OPERATION = 8'h01;
	localparam logic [7:0] CODE_CMD_PLUS = 8'hf0;
	localparam logic [7:0] CODE_DATA_PLUS_A = 8'hf1;
	localparam logic [7:0] CODE_DATA_PLUS_B = 8'hf2;
	localparam logic [7:0] CODE_FAULT_LOG = 8'hee;
	localparam logic [7:0] CODE_LOG_STORE = 8'hea;
	localparam logic [7:0] GLOBAL_CHAN = 8'hff;

	// ----------------------------------------------------------------
	// Pointer command word layout and special values
	// ----------------------------------------------------------------
	localparam int HOST_SEL_BIT = 14;
	localparam int CHAN_HI = 13;
	localparam int CHAN_LO = 9;
	localparam int PTR_HI = 8;
	localparam logic [8:0] PTR_FAULT_LOG = 9'h0ee;
	localparam logic [8:0] PTR_STATUS_A = 9'h02c;
	localparam logic [8:0] PTR_STATUS_B = 9'h02d;
	localparam logic [8:0] PTR_POKE_CTRL = 9'h1f6;
	localparam logic [4:0] POKE_EN_CHAN = 5'h05;
	localparam logic [4:0] POKE_DIS_CHAN = 5'h00;
	localparam int STAT_ABORT_BIT = 1;
	localparam int STAT_POKE_FAIL_BIT = 0;

	// ----------------------------------------------------------------
	// Fault log buffer
	// ----------------------------------------------------------------
	localparam logic [15:0] LOG_LENGTH_WORD = 16'h00ff;
	localparam logic [7:0] LOG_LAST_WORD = 8'h80;
	localparam logic [7:0] LOG_LAST_BYTE = 8'hfe;

	// ----------------------------------------------------------------
	// On/off/margin byte
	// ----------------------------------------------------------------
	localparam int RUN_HI = 7;
	localparam int RUN_LO = 6;
	localparam int MARGIN_HI = 5;
	localparam int MARGIN_LO = 4;
	localparam int FAULT_HI = 3;
	localparam int FAULT_LO = 2;
	localparam logic [1:0] RUN_OFF = 2'h0;
	localparam logic [1:0] RUN_SEQ_OFF = 2'h1;
	localparam logic [1:0] RUN_ON = 2'h2;
	localparam logic [1:0] MARGIN_LOW = 2'h1;
	localparam logic [1:0] MARGIN_HIGH = 2'h2;
	localparam logic [1:0] FAULT_IGNORE = 2'h1;
	localparam logic [1:0] FAULT_RESPOND = 2'h2;
	localparam logic [7:0] OP_RESET = 8'h00;

endpackage : ioc_pkg

// ---- ioc_far_model.sv ----
// Far-side model: code-derived peek answers, a last-poke register, and the serial fault-log feed.
// Assumes the bench acts as bus host and calls send_log between frames.
`timescale 1ns/1ps
module ioc_far_model (
	input wire logic clock,
	input wire logic poke_valid,
	input wire logic [8:0] tgt_code,
	input wire logic [15:0] poke_data,
	output logic [15:0] peek_rdata,
	output logic peek_is_byte,
	output logic log_sck,
	output logic log_sdi,
	output logic log_frame_n
);
	logic [15:0] last_poke = 16'h0000;
	// Odd codes answer as byte registers with a non-zero upper byte, so forcing is visible.
	assign peek_is_byte = tgt_code[0];
	assign peek_rdata = {7'h5a, tgt_code};
	always @(posedge clock) begin
		if (poke_valid) begin
			last_poke <= poke_data;
		end
	end
	initial begin
		log_sck = 1'b0;
		log_sdi = 1'b0;
		log_frame_n = 1'b1;
	end
	// The link clock stands still outside frames; released data shows the inverse of its last bit.
	task automatic send_log(input logic [31:0] bytes);
		logic bit_v;
		bit_v = 1'b0;
		log_frame_n = 1'b0;
		#157;
		for (int i = 0; i < 32; i++) begin
			bit_v = bytes[8 * (i / 8) + 7 - (i % 8)];
			log_sdi = bit_v;
			#100 log_sck = 1'b1;
			#100 log_sck = 1'b0;
		end
		#100 log_frame_n = 1'b1;
		log_sdi = ~bit_v;
	endtask : send_log
endmodule : ioc_far_model

// ---- ioc_checker_properties.sv ----
// Port-level checker for the indirect access and output control block.
// Assumes it is bound to ioc_indirect_ctrl and sees only its ports.
`timescale 1ns/1ps
module ioc_checker #(
	parameter int INIT_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_chan,
	input wire logic [15:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [15:0] rsp_data,
	input wire logic peek_req,
	input wire logic poke_valid,
	input wire logic [15:0] poke_data,
	input wire logic bus_honour,
	input wire logic input_supply_sense,
	input wire logic seq_permit,
	input wire logic [7:0] chan_on,
	input wire logic [7:0] chan_margin_low
);
	import ioc_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Edges since reset release; saturates so a long run cannot wrap it.
	logic [31:0] up_q;
	always_ff @(posedge clock) begin
		if (!rstn) up_q <= '0;
		else if (up_q != 32'hffffffff) up_q <= up_q + 32'h1;
	end
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence s_peek_take;
		cmd_valid && cmd_ready && !cmd_write && (cmd_code == CODE_DATA_PLUS_A || cmd_code == CODE_DATA_PLUS_B);
	endsequence
	sequence s_op_all;
		cmd_valid && cmd_ready && cmd_write && cmd_code == CODE_OPERATION && cmd_chan == GLOBAL_CHAN;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_PEEK_ANSWER: assert property (s_peek_take ##1 peek_req |=> rsp_valid)
		else $error("peek answer not one cycle after the target request");
	AST_PEEK_REFUSE: assert property (peek_req |-> !cmd_ready)
		else $error("command taken in the peek request cycle");
	AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("answer word dropped or changed before it was taken");
	AST_POKE_CAUSE: assert property (poke_valid |-> $past(cmd_valid && cmd_ready && cmd_write)
		&& $past(cmd_code == CODE_DATA_PLUS_A || cmd_code == CODE_DATA_PLUS_B) && poke_data == $past(cmd_wdata))
		else $error("poke without a matching data port write");
	AST_RESET_CLEAN: assert property (disable iff (1'b0) !rstn |=> !cmd_ready && !rsp_valid && !seq_permit
		&& !poke_valid && chan_on == '0)
		else $error("outputs not cleared by reset");
	AST_SENSE_GATE: assert property (!input_supply_sense [*4] |-> !seq_permit)
		else $error("sequencing permitted below the input threshold");
	AST_INIT_GATE: assert property (seq_permit |-> up_q >= INIT_CYCLES)
		else $error("sequencing permitted before initialisation time");
	AST_OP_MARGIN: assert property (s_op_all |-> ##2 chan_margin_low == {8{$past(cmd_wdata[5:4], 2) == MARGIN_LOW}})
		else $error("global margin select not applied to every channel");
	AST_OP_ON: assert property (s_op_all and (bus_honour && seq_permit && cmd_wdata[7:6] == RUN_ON)
		|-> ##3 chan_on == 8'hff)
		else $error("global turn-on not applied");
	AST_OP_NO_RUN: assert property (s_op_all and !bus_honour |=> $stable(chan_on) [*3])
		else $error("run field acted on while bus commands are not honoured");
endmodule : ioc_checker
bind ioc_indirect_ctrl ioc_checker #(.INIT_CYCLES(INIT_CYCLES)) CHK (.clock(clock), .rstn(rstn),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_code(cmd_code),
	.cmd_chan(cmd_chan), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
	.rsp_data(rsp_data), .peek_req(peek_req), .poke_valid(poke_valid), .poke_data(poke_data),
	.bus_honour(bus_honour), .input_supply_sense(input_supply_sense), .seq_permit(seq_permit),
	.chan_on(chan_on), .chan_margin_low(chan_margin_low));

// ---- ioc_indirect_ctrl_bench.sv ----
// Self-checking bench for the indirect access and output control block.
// Assumes the far-side model file and the checker are compiled with the design.
`timescale 1ns/1ps
module ioc_indirect_ctrl_bench;
	import ioc_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0, cmd_write = 1'b0, rsp_ready = 1'b1, bus_honour = 1'b0, input_supply_sense = 1'b1;
	logic [7:0] cmd_code = 8'h00, cmd_chan = 8'h00;
	logic [15:0] cmd_wdata = 16'h0000, d, exp_poke;
	logic cmd_ready, rsp_valid, peek_req, poke_valid, peek_is_byte, log_sck, log_sdi, log_frame_n, seq_permit, h;
	logic [15:0] rsp_data, poke_data, peek_rdata;
	logic [4:0] tgt_chan;
	logic [8:0] tgt_code;
	logic [7:0] chan_on, chan_seq_off, chan_margin_low, chan_margin_high, chan_ignore_faults;
	int err_total = 0;
	int n_checks = 0;
	// Plain stand-in for the minimum off interval that the host keeps.
	localparam int OFF_MIN_CYCLES = 16;
	logic [15:0] pk_ctl [5] = '{16'h0021, 16'h0bf6, 16'h01f6, 16'h4bf6, 16'h41f6};
	logic [15:0] lw [3] = '{16'h00ff, 16'hb2a1, 16'hd4c3};
	// Columns: honour, channel, data, then expected on, seq-off, low, high, ignore.
	logic [63:0] ops [6] = '{64'h01ff97ff00ff00ff, 64'h01ff6800ff00ff00, 64'h01ff80ff00000000,
		64'h00ff14ff00ff00ff, 64'h010200fb00fb00fb, 64'h01ff2b000000ff00};
	always #12.5 clock = ~clock;
	ioc_indirect_ctrl #(.INIT_CYCLES(20)) DUT (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_chan(cmd_chan),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
		.peek_req(peek_req), .poke_valid(poke_valid), .tgt_chan(tgt_chan), .tgt_code(tgt_code),
		.poke_data(poke_data), .peek_rdata(peek_rdata), .peek_is_byte(peek_is_byte), .log_sck(log_sck),
		.log_sdi(log_sdi), .log_frame_n(log_frame_n), .bus_honour(bus_honour),
		.input_supply_sense(input_supply_sense), .seq_permit(seq_permit), .chan_on(chan_on),
		.chan_seq_off(chan_seq_off), .chan_margin_low(chan_margin_low), .chan_margin_high(chan_margin_high),
		.chan_ignore_faults(chan_ignore_faults));
	ioc_far_model FAR (.clock(clock), .poke_valid(poke_valid), .tgt_code(tgt_code), .poke_data(poke_data),
		.peek_rdata(peek_rdata), .peek_is_byte(peek_is_byte), .log_sck(log_sck), .log_sdi(log_sdi),
		.log_frame_n(log_frame_n));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [15:0] ptr(input logic hs, input logic [4:0] ch, input logic [8:0] code);
		return {1'b0, hs, ch, code};
	endfunction : ptr
	// Holds the request from one rising edge until the edge at which it is taken.
	task automatic issue(input logic wr, input logic [7:0] code, input logic [7:0] ch, input logic [15:0] data);
		int n;
		n = 0;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code <= code;
		cmd_chan <= ch;
		cmd_wdata <= data;
		@(negedge clock);
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		chk("cmd_ready", 16'h0001, {15'h0, cmd_ready});
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask : issue
	task automatic rd(input logic [7:0] code, input logic [7:0] ch, output logic [15:0] data);
		int n;
		n = 0;
		issue(1'b0, code, ch, 16'h0000);
		@(negedge clock);
		while (rsp_valid !== 1'b1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		chk("rsp_valid", 16'h0001, {15'h0, rsp_valid});
		data = rsp_data;
		@(posedge clock);
	endtask : rd
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#2000000;
		err_total++;
		print_verdict();
	end
	initial begin
		exp_poke = 16'h0000;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		repeat (10) @(negedge clock);
		chk("seq_permit", 16'h0000, {15'h0, seq_permit});
		repeat (20) @(negedge clock);
		chk("seq_permit", 16'h0001, {15'h0, seq_permit});
		@(posedge clock);
		input_supply_sense <= 1'b0;
		repeat (6) @(negedge clock);
		chk("seq_permit", 16'h0000, {15'h0, seq_permit});
		@(posedge clock);
		input_supply_sense <= 1'b1;
		repeat (6) @(negedge clock);
		chk("seq_permit", 16'h0001, {15'h0, seq_permit});
		rd(CODE_OPERATION, 8'h02, d);
		chk("operation reset", {8'h00, OP_RESET}, d);
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b0, 5'h03, 9'h021));
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b1, 5'h04, 9'h020));
		rd(CODE_DATA_PLUS_B, 8'h00, d);
		chk("peek word b", {7'h5a, 9'h020}, d);
		chk("tgt_chan b", 16'h0004, {11'h0, tgt_chan});
		rd(CODE_DATA_PLUS_A, 8'h00, d);
		chk("peek byte a", {8'h00, 8'h21}, d);
		chk("tgt_chan a", 16'h0003, {11'h0, tgt_chan});
		foreach (pk_ctl[i]) begin
			h = pk_ctl[i][14];
			issue(1'b1, CODE_CMD_PLUS, 8'h00, pk_ctl[i]);
			issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(h, 5'h03, 9'h021));
			issue(1'b1, h ? CODE_DATA_PLUS_B : CODE_DATA_PLUS_A, 8'h00, 16'h1230 + 16'(i));
			repeat (3) @(negedge clock);
			if (pk_ctl[i][11]) exp_poke = 16'h1230 + 16'(i);
			chk("poke data", exp_poke, FAR.last_poke);
			issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(h, 5'h00, h ? PTR_STATUS_B : PTR_STATUS_A));
			rd(h ? CODE_DATA_PLUS_B : CODE_DATA_PLUS_A, 8'h00, d);
			chk("poke status", {15'h0, ~pk_ctl[i][11]}, d);
		end
		FAR.send_log(32'hd4c3b2a1);
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b0, 5'h00, PTR_FAULT_LOG));
		for (int i = 0; i < 130; i++) begin
			rd(CODE_DATA_PLUS_A, 8'h00, d);
			if (i == 1) issue(1'b1, CODE_OPERATION, 8'h02, 16'h0020);
			if (i < 3) chk("log word", lw[i], d);
			if (i > 128) chk("log past end", 16'h0000, d);
		end
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b0, 5'h00, PTR_STATUS_A));
		rd(CODE_DATA_PLUS_A, 8'h00, d);
		chk("status a", 16'h0001, d);
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b0, 5'h00, PTR_FAULT_LOG));
		issue(1'b1, CODE_LOG_STORE, 8'h00, 16'h0000);
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b0, 5'h00, PTR_STATUS_A));
		rd(CODE_DATA_PLUS_A, 8'h00, d);
		chk("status a abort", 16'h0003, d);
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b1, 5'h00, PTR_FAULT_LOG));
		rd(CODE_DATA_PLUS_B, 8'h00, d);
		chk("log word b", LOG_LENGTH_WORD, d);
		issue(1'b0, CODE_FAULT_LOG, 8'h00, 16'h0000);
		rd(CODE_DATA_PLUS_B, 8'h00, d);
		chk("aborted word", 16'h0000, d);
		issue(1'b1, CODE_CMD_PLUS, 8'h00, ptr(1'b1, 5'h00, PTR_STATUS_B));
		rd(CODE_DATA_PLUS_B, 8'h00, d);
		chk("status b", 16'h0003, d);
		foreach (ops[i]) begin
			bus_honour <= ops[i][56];
			issue(1'b1, CODE_OPERATION, ops[i][55:48], {8'h00, ops[i][47:40]});
			repeat (4) @(negedge clock);
			chk("chan_on", {8'h00, ops[i][39:32]}, {8'h00, chan_on});
			chk("chan_seq_off", {8'h00, ops[i][31:24]}, {8'h00, chan_seq_off});
			chk("chan_margin_low", {8'h00, ops[i][23:16]}, {8'h00, chan_margin_low});
			chk("chan_margin_high", {8'h00, ops[i][15:8]}, {8'h00, chan_margin_high});
			chk("chan_ignore_faults", {8'h00, ops[i][7:0]}, {8'h00, chan_ignore_faults});
			rd(CODE_OPERATION, 8'h02, d);
			chk("operation readback", {8'h00, ops[i][47:40] & 8'hfc}, d);
			repeat (OFF_MIN_CYCLES) @(posedge clock);
		end
		// Two answers with the receiver stalled must fill the buffer and refuse a third.
		rsp_ready <= 1'b0;
		issue(1'b0, CODE_OPERATION, 8'h02, 16'h0000);
		issue(1'b0, CODE_OPERATION, 8'h02, 16'h0000);
		repeat (3) @(negedge clock);
		chk("buffer full", 16'h0000, {15'h0, cmd_ready});
		@(posedge clock);
		rsp_ready <= 1'b1;
		repeat (2) begin
			@(negedge clock);
			chk("drained word", 16'h0028, rsp_data);
			chk("drained valid", 16'h0001, {15'h0, rsp_valid});
			@(posedge clock);
		end
		@(negedge clock);
		chk("buffer empty", 16'h0000, {15'h0, rsp_valid});
		print_verdict();
	end
endmodule : ioc_indirect_ctrl_bench
